/* adc_enable_sequencer.sv */
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module adc_enable_sequencer
    import aes_pkg::*;
#(
    parameter bit VARIANT = 1'b1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic ready,
    output logic conv_busy,
    output logic conv_done
);
    // ****************************************
    // registers
    // ****************************************
    logic enable_r;
    logic [1:0] sel_r;
    logic [7:0] ct_r;
    logic conv_start_r;
    logic ack_r;
    logic waitreq_r;
    logic [31:0] rdata_r;
    logic ready_r;
    logic busy_r;
    logic done_r;
    logic [11:0] target_r;
    aes_ctl_if ctl ();

    function automatic logic [11:0] f_settle(input logic v, input logic [7:0] ct,
                                             input logic [1:0] sel);
        logic [5:0] base;
        logic [6:0] ratio;
        base = 6'h00;
        ratio = 7'h00;
        // RQ3 base select
        unique case (sel)
            2'b00: base = AES_SEL0;
            2'b01: base = AES_SEL1;
            2'b10: base = AES_SEL2;
            2'b11: base = AES_SEL3;
        endcase
        // RQ5 ratio one code
        ratio = (ct == AES_RATIO1_CODE) ? 7'h01 : 7'(ct[5:0]) + 7'h02;
        // RQ1 first variant table
        if (!v) f_settle = AES_V0_BASE + 12'(ct[2:0]) * AES_V0_STEP;
        // RQ4 base times ratio
        else f_settle = 12'(base) * 12'(ratio);
    endfunction : f_settle

    wire logic req = (avs_read | avs_write) & ~ack_r;
    // write lands on the edge the master sees waitrequest low
    wire logic wr = avs_write & ack_r & avs_byteenable[0];
    wire logic wr_en = wr & (avs_address == AES_OFS_ENABLE);
    wire logic wr_ct = wr & (avs_address == AES_OFS_COMPARE);
    wire logic wr_cv = wr & (avs_address == AES_OFS_CONV);
    // RQ17 RQ15 reserved read zero
    wire logic [7:0] en_rd = VARIANT ? {2'b00, sel_r, 2'b00, ready_r, enable_r}
                                     : {6'h00, ready_r, enable_r};
    wire logic [7:0] ct_rd = VARIANT ? ct_r : {5'h00, ct_r[2:0]};
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        unique case (avs_address)
            AES_OFS_ENABLE: rmux = {24'h000000, en_rd};
            AES_OFS_COMPARE: rmux = {24'h000000, ct_rd};
            AES_OFS_STATUS: rmux = {30'h0, done_r, busy_r};
            default: rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            waitreq_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            waitreq_r <= ~req;
            rdata_r <= rmux;
        end
    end

    // RQ16 enable and select reset to zero; compare setup resets to 8'h07
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_r <= 1'b0;
            sel_r <= 2'b00;
            ct_r <= VARIANT ? AES_CT_RESET_V1 : AES_CT_RESET_V0;
            conv_start_r <= 1'b0;
        end else begin
            // RQ9 enable bit write
            if (wr_en) enable_r <= avs_writedata[AES_BIT_ENABLE];
            if (wr_en && VARIANT) sel_r <= avs_writedata[AES_SEL_LSB +: 2];
            if (wr_ct) ct_r <= VARIANT ? avs_writedata[7:0] : {5'h00, avs_writedata[2:0]};
            conv_start_r <= wr_cv & avs_writedata[0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            target_r <= 12'h000;
            ready_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            target_r <= f_settle(VARIANT, ct_r, sel_r);
            ready_r <= ctl.ready;
            busy_r <= ctl.conv_busy;
            done_r <= ctl.conv_done;
        end
    end

    // ****************************************
    // submodules
    // ****************************************
    aes_settle_timer u_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .enable(enable_r),
        .target(target_r),
        .ctl(ctl.seq)
    );
    aes_conv_engine u_conv (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(conv_start_r),
        .ctl(ctl.conv)
    );

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = waitreq_r;
    assign ready = ready_r;
    assign conv_busy = busy_r;
    assign conv_done = done_r;
endmodule : adc_enable_sequencer

/* aes_pkg.sv */
// Functional notes
// RQ1: first variant settling is 72 to 324 cycles by 3-bit divider code.
// RQ2: converter stays in transition for base period times settling cycles.
// RQ3: second variant base count: 00=36, 01=20, 10=9, 11=44 cycles.
// RQ4: second variant settling count is base count times division ratio.
// RQ5: code 0x80 gives ratio one; 0x00..0x3f give ratios two to 65.
// RQ6: read-only ready bit is 1 when enabled, 0 when stopped.
// RQ7: conversion requests while stopped are dropped, never held.
// RQ8: leaving enabled state aborts a running conversion at once.
// RQ9: enable 1 reaches ready after settling; enable 0 stops immediately.
// RQ10: software writes compare setup only when idle, not settling or converting.
// RQ11: first variant: program compare setup before the enable register.
// RQ12: second variant: divider, then base select, then enable.
// RQ13: software leaves base select alone during settling.
// RQ14: software clears enable before entering low-power modes.
// RQ15: second variant reserved bits 7:6 and 3:2 read undefined.
// RQ16: base select at bits 5:4 read-write; select, ready, enable reset zero.
// RQ17: first variant bits 7:2 reserved, read zero.
// RQ18: each enable from stopped restarts count; clear during settling cancels.
// RQ19: ready rises cycle after last settling cycle, falls as enable clears.
package aes_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] AES_OFS_ENABLE = 4'h0;
    localparam logic [3:0] AES_OFS_COMPARE = 4'h4;
    localparam logic [3:0] AES_OFS_CONV = 4'h8;
    localparam logic [3:0] AES_OFS_STATUS = 4'hc;
    localparam int AES_BIT_ENABLE = 0;
    localparam int AES_BIT_READY = 1;
    localparam int AES_SEL_LSB = 4;
    localparam logic [7:0] AES_CT_RESET_V0 = 8'h07;
    localparam logic [7:0] AES_CT_RESET_V1 = 8'h07;
    localparam logic [7:0] AES_RATIO1_CODE = 8'h80;
    // ****************************************
    // settling counts
    // ****************************************
    localparam logic [11:0] AES_V0_BASE = 12'h048;
    localparam logic [11:0] AES_V0_STEP = 12'h024;
    localparam logic [5:0] AES_SEL0 = 6'h24;
    localparam logic [5:0] AES_SEL1 = 6'h14;
    localparam logic [5:0] AES_SEL2 = 6'h09;
    localparam logic [5:0] AES_SEL3 = 6'h2c;
    localparam int AES_CLK_MHZ = 125;
    localparam int AES_CONV_NS = 1000;
    localparam int AES_CONV_CYC = (AES_CONV_NS * AES_CLK_MHZ + 999) / 1000;
    localparam int AES_CNT_W = 12;
    typedef enum logic [1:0] {
        AES_STOPPED = 2'b00,
        AES_SETTLING = 2'b01,
        AES_ENABLED = 2'b11
    } aes_state_e;
endpackage : aes_pkg

/* aes_ctl_if.sv */
`timescale 1ns/1ps
interface aes_ctl_if;
    logic ready;
    logic conv_busy;
    logic conv_done;
    modport seq (output ready, input conv_busy, conv_done);
    modport conv (input ready, output conv_busy, conv_done);
endinterface : aes_ctl_if

/* aes_conv_engine.sv */
`timescale 1ns/1ps
module aes_conv_engine
    import aes_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    aes_ctl_if.conv ctl
);
    // ****************************************
    // conversion timer
    // ****************************************
    logic [7:0] cnt_r;
    logic busy_r;
    logic done_r;
    wire logic accept = start & ctl.ready & ~busy_r;
    wire logic last = busy_r & (cnt_r == 8'(AES_CONV_CYC - 1));
    assign ctl.conv_busy = busy_r;
    assign ctl.conv_done = done_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            done_r <= 1'b0;
        // RQ8 abort on stop
        end else if (!ctl.ready) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            // RQ7 drop when stopped
            busy_r <= accept | (busy_r & ~last);
            cnt_r <= busy_r ? cnt_r + 8'h01 : 8'h00;
            done_r <= last;
        end
    end
endmodule : aes_conv_engine

/* aes_settle_timer.sv */
`timescale 1ns/1ps
module aes_settle_timer
    import aes_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic [11:0] target,
    aes_ctl_if.seq ctl
);
    // ****************************************
    // enable sequencer
    // ****************************************
    aes_state_e state_r;
    aes_state_e state_nxt;
    logic [11:0] cnt_r;
    wire logic expired = (cnt_r == target - 12'h001);
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            AES_STOPPED: if (enable) state_nxt = AES_SETTLING;
            AES_SETTLING: begin
                // RQ18 cancel on clear
                if (!enable) state_nxt = AES_STOPPED;
                // RQ19 ready after last
                else if (expired) state_nxt = AES_ENABLED;
            end
            AES_ENABLED: if (!enable) state_nxt = AES_STOPPED;
            default: state_nxt = AES_STOPPED;
        endcase
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= AES_STOPPED;
            cnt_r <= 12'h000;
        end else begin
            state_r <= state_nxt;
            // RQ2 count settling cycles
            cnt_r <= (state_r == AES_SETTLING) ? cnt_r + 12'h001 : 12'h000;
        end
    end
    // RQ6 ready from state
    assign ctl.ready = (state_r == AES_ENABLED);
endmodule : aes_settle_timer

/* aes_monitor.sv */
`timescale 1ns/1ps
module aes_monitor
    import aes_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic ready,
    input wire logic conv_busy,
    input wire logic conv_done
);
    // ***
    // checks
    // ***
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire logic rd_ok = avs_read && !avs_waitrequest;
    wire logic en_wr = wr_ok && avs_address == AES_OFS_ENABLE;
    property p_stop; en_wr && !avs_writedata[0] |-> ##[1:3] !ready; endproperty
    a_stop: assert property (p_stop) else $error("ready kept after stop");
    property p_early; en_wr && avs_writedata[0] && !ready |-> ##1 !ready [*8]; endproperty
    a_early: assert property (p_early) else $error("ready too early");
    property p_gate; $rose(conv_busy) |-> $past(ready); endproperty
    a_gate: assert property (p_gate) else $error("conversion while stopped");
    property p_abort; $fell(ready) |-> ##[0:3] !conv_busy; endproperty
    a_abort: assert property (p_abort) else $error("conversion not aborted");
    property p_pulse; conv_done |=> !conv_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done not a pulse");
    property p_drop;
        wr_ok && avs_address == AES_OFS_CONV && !ready |-> ##1 !conv_busy [*4];
    endproperty
    a_drop: assert property (p_drop) else $error("request kept while stopped");
    property p_rsv; rd_ok && avs_address == AES_OFS_ENABLE |-> avs_readdata[31:6] == 26'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_ack; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("read answer late");
    c_up: cover property ($rose(ready));
    c_done: cover property (conv_done);
    c_cut: cover property ($fell(ready) && conv_busy);
endmodule : aes_monitor

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import aes_pkg::*;
    logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, ready, conv_busy, conv_done;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, avs_readdata0, rd0;
    logic avs_waitrequest0, ready0, conv_busy0, conv_done0;
    logic [7:0] ct;
    int fails, compares, n, nexp;
    int bases[4] = '{36, 20, 9, 44};
    adc_enable_sequencer #(.VARIANT(1'b1)) DUT (.ref_clk, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ready,
        .conv_busy, .conv_done);
    // first variant shares the bus and answers in step with DUT
    adc_enable_sequencer #(.VARIANT(1'b0)) DUT0 (.ref_clk, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata(avs_readdata0),
        .avs_waitrequest(avs_waitrequest0), .ready(ready0), .conv_busy(conv_busy0),
        .conv_done(conv_done0));
    // ***
    // tasks
    // ***
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_win(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : check_win
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rd0 = avs_readdata0;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic give_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end
    initial begin
        reset_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        void'($urandom(32'hc3c0));
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        bus(0, AES_OFS_ENABLE, 0);
        check_val(rd, 32'h0);
        bus(0, AES_OFS_COMPARE, 0);
        check_val(rd, 32'h7);
        bus(1, AES_OFS_CONV, 32'h1);
        repeat (4) @(posedge ref_clk);
        check_val(32'(conv_busy), 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            ct = (i == 0) ? 8'h80 : (i == 3) ? 8'h3f : 8'($urandom % 64);
            nexp = bases[i] * ((ct == 8'h80) ? 1 : int'(ct[5:0]) + 2);
            bus(1, AES_OFS_COMPARE, {24'h0, ct});
            bus(1, AES_OFS_ENABLE, 32'(i << 4));
            bus(1, AES_OFS_ENABLE, 32'(i << 4 | 1));
            repeat (4) @(posedge ref_clk);
            bus(1, AES_OFS_ENABLE, 32'(i << 4));
            repeat (nexp + 8) @(posedge ref_clk);
            check_val(32'(ready), 32'h0);
            bus(1, AES_OFS_ENABLE, 32'(i << 4 | 1));
            for (n = 0; ready !== 1'b1 && n < 4000; n++) @(posedge ref_clk);
            check_win(n, nexp, nexp + 5);
            bus(0, AES_OFS_ENABLE, 0);
            check_val(rd, 32'(i << 4 | 3));
            bus(1, AES_OFS_CONV, 32'h1);
            for (n = 0; conv_busy !== 1'b1 && n < 10; n++) @(posedge ref_clk);
            check_val(32'(conv_busy), 32'h1);
            if (i % 2) begin
                for (n = 0; conv_done !== 1'b1 && n < 200; n++) @(posedge ref_clk);
                check_val(32'(conv_done), 32'h1);
            end
            bus(1, AES_OFS_ENABLE, 32'(i << 4));
            repeat (4) @(posedge ref_clk);
            check_val({ready, conv_busy}, 32'h0);
            $display("test select %0d ratio code %h done", i, ct);
        end
        for (int i = 0; i < 3; i++) begin
            ct = (i == 0) ? 8'h00 : (i == 1) ? 8'h07 : 8'($urandom % 8);
            nexp = 72 + 36 * int'(ct);
            bus(1, AES_OFS_COMPARE, {24'h0, ct});
            bus(1, AES_OFS_ENABLE, 32'h1);
            for (n = 0; ready0 !== 1'b1 && n < 400; n++) @(posedge ref_clk);
            check_win(n, nexp, nexp + 5);
            bus(0, AES_OFS_ENABLE, 0);
            check_val(rd0, 32'h3);
            bus(0, AES_OFS_COMPARE, 0);
            check_val(rd0, 32'(ct));
            bus(1, AES_OFS_ENABLE, 32'h0);
            repeat (4) @(posedge ref_clk);
            check_val(32'(ready0), 32'h0);
            $display("test first variant code %h done", ct);
        end
        give_verdict();
    end
endmodule : tb
bind adc_enable_sequencer aes_monitor u_mon (.ref_clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ready,
    .conv_busy, .conv_done);
